// File: rtl/traffic_alarm_pkg.sv
package traffic_alarm_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_BER_THR = 12'h004;
  localparam logic [11:0] ADDR_EBNO_THR = 12'h008;
  localparam logic [11:0] ADDR_SLIP_THR = 12'h00C;
  localparam logic [11:0] ADDR_DIST_THR = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h018;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h01C;
  localparam logic [11:0] ADDR_CRC_CNT = 12'h020;
  localparam logic [11:0] ADDR_EBIT_CNT = 12'h024;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTL_AUTOCENTRE = 0;
  localparam int CTL_BER_ACT = 1;
  localparam int CTL_AIS_ACT = 2;
  localparam int CTL_BACK_LO = 3;
  localparam int CTL_CRC_PROC = 5;
  localparam int CTL_EBIT_RET = 6;
  localparam int CTL_STRICT_ACQ = 7;
  localparam int CTL_DROP_INSERT = 8;
  localparam int CTL_CAS = 9;
  localparam int CTL_INS_ACTIVE = 10;
  localparam int CTL_CRC_SRC = 11;
  localparam int CTL_E1_BEARER = 12;
  localparam logic [12:0] CTRL_RESET = 13'h0007;
  // ----------------------------------------------------------------
  // irq bit positions (the status register shares only bits 0 and 1)
  // ----------------------------------------------------------------
  localparam int ST_PROMPT = 0;
  localparam int ST_DEFERRED = 1;
  localparam int ST_SLIP = 2;
  localparam int ST_REACQ = 3;
  localparam int ST_RECENTRE = 4;
  localparam int IRQ_W = 5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int CRC_SYNC_MS = 8;
  localparam int CRC_SYNC_CYC = CLK_HZ / 1000 * CRC_SYNC_MS;
  localparam int HOUR_S = 3600;
  localparam longint CYC_PER_HOUR = longint'(CLK_HZ) * longint'(HOUR_S);
  localparam logic [15:0] SLIP_THR_RESET = 16'h03C0;
  typedef enum logic [1:0] {BACK_NORMAL, BACK_ALL_ONES, BACK_B_ONE, BACK_AB_ONE} back_mode_t;
  typedef struct packed {
    logic [3:0] sig_force;
    logic [3:0] sig_value;
  } sig_ovr_t;
endpackage

// File: rtl/traffic_alarm_consequent_actions.sv
`timescale 1ns/1ns
module traffic_alarm_consequent_actions
  import traffic_alarm_pkg::*;
#(
  parameter int CRC_SYNC_CYCLES = CRC_SYNC_CYC,
  parameter longint HOUR_CYCLES = CYC_PER_HOUR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_traffic_fail,
  input wire logic high_error,
  input wire logic all_ones_detected,
  input wire logic [15:0] user_err_est,
  input wire logic [15:0] demod_ebno,
  input wire logic [15:0] distant_ebno,
  input wire logic auto_uplink_power_control,
  input wire logic buffer_slip,
  input wire logic backward_alarm_rx,
  input wire logic crc_error,
  input wire logic ebit_rx,
  input wire logic crc_mf_sync,
  output logic buffer_recentre,
  output logic prompt_alarm,
  output logic deferred_alarm,
  output logic force_all_ones,
  output logic backward_alarm_tx,
  output logic insert_backward_alarm,
  output sig_ovr_t sig_override,
  output logic ebit_tx,
  output logic frame_reacquire,
  output logic irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [12:0] ctrl_q;
  logic [15:0] ber_thr_q;
  logic [15:0] ebno_thr_q;
  logic [15:0] slip_thr_q;
  logic [15:0] dist_thr_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [15:0] crc_cnt_q;
  logic [15:0] ebit_cnt_q;
  logic [IRQ_W-1:0] ev;
  logic wr_en;
  logic rd_en;
  logic crc_on;
  back_mode_t back_mode;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a <= ADDR_EBIT_CNT) && (a[1:0] == 2'b00);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign back_mode = back_mode_t'(ctrl_q[CTL_BACK_LO+1:CTL_BACK_LO]);
  assign crc_on = ctrl_q[CTL_CRC_PROC] && ctrl_q[CTL_DROP_INSERT] && ctrl_q[CTL_E1_BEARER];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      ber_thr_q <= 16'hFFFF;
      ebno_thr_q <= 16'h0000;
      slip_thr_q <= SLIP_THR_RESET;
      dist_thr_q <= 16'h0000;
      irq_mask_q <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: ctrl_q <= pwdata[12:0];
        ADDR_BER_THR: ber_thr_q <= pwdata[15:0];
        ADDR_EBNO_THR: ebno_thr_q <= pwdata[15:0];
        ADDR_SLIP_THR: slip_thr_q <= pwdata[15:0];
        ADDR_DIST_THR: dist_thr_q <= pwdata[15:0];
        ADDR_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb read and answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok(paddr);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata <= {19'h0, ctrl_q};
          ADDR_BER_THR: prdata <= {16'h0, ber_thr_q};
          ADDR_EBNO_THR: prdata <= {16'h0, ebno_thr_q};
          ADDR_SLIP_THR: prdata <= {16'h0, slip_thr_q};
          ADDR_DIST_THR: prdata <= {16'h0, dist_thr_q};
          ADDR_STATUS: prdata <= {27'h0, frame_reacquire, force_all_ones, backward_alarm_tx,
                                  deferred_alarm, prompt_alarm};
          ADDR_IRQ_STAT: prdata <= {27'h0, irq_stat_q};
          ADDR_IRQ_MASK: prdata <= {27'h0, irq_mask_q};
          ADDR_CRC_CNT: prdata <= {16'h0, crc_cnt_q};
          ADDR_EBIT_CNT: prdata <= {16'h0, ebit_cnt_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // buffer recentre
  // ----------------------------------------------------------------
  logic fail_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 1'b0;
      buffer_recentre <= 1'b0;
    end else begin
      fail_q <= rx_traffic_fail;
      buffer_recentre <= fail_q && !rx_traffic_fail && ctrl_q[CTL_AUTOCENTRE];
    end
  end

  // ----------------------------------------------------------------
  // prompt actions
  // ----------------------------------------------------------------
  logic ais_act;
  logic ais_alarm;
  assign ais_act = all_ones_detected && ctrl_q[CTL_AIS_ACT] && !ctrl_q[CTL_DROP_INSERT];
  assign ais_alarm = ais_act;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prompt_alarm <= 1'b0;
      force_all_ones <= 1'b0;
      backward_alarm_tx <= 1'b0;
    end else begin
      prompt_alarm <= high_error || ais_alarm;
      force_all_ones <= (high_error && ctrl_q[CTL_BER_ACT]) || ais_act
                        || (all_ones_detected && ctrl_q[CTL_DROP_INSERT]);
      backward_alarm_tx <= (high_error && ctrl_q[CTL_BER_ACT]) || ais_alarm;
    end
  end

  // ----------------------------------------------------------------
  // incoming backward alarm handling
  // ----------------------------------------------------------------
  logic cas_ins;
  assign cas_ins = ctrl_q[CTL_INS_ACTIVE] && ctrl_q[CTL_CAS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insert_backward_alarm <= 1'b0;
      sig_override <= '0;
    end else begin
      insert_backward_alarm <= backward_alarm_rx && (!cas_ins || back_mode == BACK_NORMAL);
      sig_override.sig_value <= 4'hF;
      if (backward_alarm_rx && cas_ins) begin
        case (back_mode)
          BACK_ALL_ONES: sig_override.sig_force <= 4'hF;
          BACK_B_ONE: sig_override.sig_force <= 4'h4;
          BACK_AB_ONE: sig_override.sig_force <= 4'hC;
          default: sig_override.sig_force <= 4'h0;
        endcase
      end else begin
        sig_override.sig_force <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bearer crc, e-bits, reacquisition
  // ----------------------------------------------------------------
  logic [22:0] sync_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_cnt_q <= 16'h0000;
      ebit_cnt_q <= 16'h0000;
      ebit_tx <= 1'b0;
    end else begin
      if (crc_on && ctrl_q[CTL_CRC_SRC] && crc_error && crc_cnt_q != 16'hFFFF) begin
        crc_cnt_q <= crc_cnt_q + 16'h0001;
      end
      if (crc_on && ebit_rx && ebit_cnt_q != 16'hFFFF) begin
        ebit_cnt_q <= ebit_cnt_q + 16'h0001;
      end
      ebit_tx <= crc_on && ctrl_q[CTL_EBIT_RET] && crc_error;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt_q <= '0;
      frame_reacquire <= 1'b0;
    end else begin
      frame_reacquire <= 1'b0;
      if (!crc_on || !ctrl_q[CTL_STRICT_ACQ] || crc_mf_sync) begin
        sync_cnt_q <= '0;
      end else if (sync_cnt_q >= 23'(CRC_SYNC_CYCLES - 1)) begin
        sync_cnt_q <= '0;
        frame_reacquire <= 1'b1;
      end else begin
        sync_cnt_q <= sync_cnt_q + 23'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // deferred alarm and slip interval
  // ----------------------------------------------------------------
  logic [37:0] hour_div_q;
  logic [15:0] hours_q;
  logic slip_seen_q;
  logic slip_short_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hour_div_q <= '0;
      hours_q <= 16'h0000;
      slip_seen_q <= 1'b0;
      slip_short_q <= 1'b0;
    end else begin
      if (buffer_slip) begin
        hour_div_q <= '0;
        hours_q <= 16'h0000;
        slip_seen_q <= 1'b1;
        slip_short_q <= slip_seen_q && (hours_q < slip_thr_q);
      end else if (hour_div_q >= 38'(HOUR_CYCLES - 1)) begin
        hour_div_q <= '0;
        if (hours_q != 16'hFFFF) begin
          hours_q <= hours_q + 16'h0001;
        end
      end else begin
        hour_div_q <= hour_div_q + 38'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deferred_alarm <= 1'b0;
    end else begin
      deferred_alarm <= (user_err_est > ber_thr_q)
                        || (demod_ebno < ebno_thr_q)
                        || slip_short_q
                        || (auto_uplink_power_control && distant_ebno < dist_thr_q);
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign ev[ST_PROMPT] = high_error || ais_alarm;
  assign ev[ST_DEFERRED] = deferred_alarm;
  assign ev[ST_SLIP] = buffer_slip;
  assign ev[ST_REACQ] = frame_reacquire;
  assign ev[ST_RECENTRE] = buffer_recentre;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_recentre;
    @(posedge pclk) disable iff (!presetn)
    $fell(rx_traffic_fail) && ctrl_q[CTL_AUTOCENTRE] |=> buffer_recentre;
  endproperty
  a_recentre: assert property (p_recentre) else $error("no recentre");
  property p_no_recentre;
    @(posedge pclk) disable iff (!presetn)
    buffer_recentre |-> $past(ctrl_q[CTL_AUTOCENTRE]);
  endproperty
  a_no_recentre: assert property (p_no_recentre) else $error("recentre off");
  property p_ber;
    @(posedge pclk) disable iff (!presetn)
    high_error && ctrl_q[CTL_BER_ACT] |=> prompt_alarm && force_all_ones && backward_alarm_tx;
  endproperty
  a_ber: assert property (p_ber) else $error("high error actions");
  property p_ber_prompt;
    @(posedge pclk) disable iff (!presetn)
    high_error |=> prompt_alarm;
  endproperty
  a_ber_prompt: assert property (p_ber_prompt) else $error("prompt missing");
  property p_ais;
    @(posedge pclk) disable iff (!presetn)
    all_ones_detected && ctrl_q[CTL_AIS_ACT] && !ctrl_q[CTL_DROP_INSERT]
      |=> prompt_alarm && force_all_ones && backward_alarm_tx;
  endproperty
  a_ais: assert property (p_ais) else $error("no all-ones actions");
  property p_ais_di;
    @(posedge pclk) disable iff (!presetn)
    all_ones_detected && ctrl_q[CTL_DROP_INSERT] && !high_error
      |=> force_all_ones && !prompt_alarm && !backward_alarm_tx;
  endproperty
  a_ais_di: assert property (p_ais_di) else $error("drop insert all-ones");
  property p_ais_off;
    @(posedge pclk) disable iff (!presetn)
    all_ones_detected && !ctrl_q[CTL_AIS_ACT] && !ctrl_q[CTL_DROP_INSERT] && !high_error
      |=> !prompt_alarm && !force_all_ones && !backward_alarm_tx;
  endproperty
  a_ais_off: assert property (p_ais_off) else $error("ais actions not off");
  property p_insert;
    @(posedge pclk) disable iff (!presetn)
    backward_alarm_rx && cas_ins && back_mode == BACK_NORMAL |=> insert_backward_alarm;
  endproperty
  a_insert: assert property (p_insert) else $error("backward alarm not passed");
  property p_deferred_user;
    @(posedge pclk) disable iff (!presetn)
    user_err_est > ber_thr_q |=> deferred_alarm;
  endproperty
  a_deferred_user: assert property (p_deferred_user) else $error("no user deferred");
  property p_deferred_dist;
    @(posedge pclk) disable iff (!presetn)
    auto_uplink_power_control && distant_ebno < dist_thr_q |=> deferred_alarm;
  endproperty
  a_deferred_dist: assert property (p_deferred_dist) else $error("no distant deferred");
  property p_prompt_clear;
    @(posedge pclk) disable iff (!presetn)
    !high_error && !all_ones_detected |=> !prompt_alarm;
  endproperty
  a_prompt_clear: assert property (p_prompt_clear) else $error("prompt stuck");
  property p_sig_b;
    @(posedge pclk) disable iff (!presetn)
    backward_alarm_rx && cas_ins && back_mode == BACK_B_ONE |=> sig_override.sig_force == 4'h4;
  endproperty
  a_sig_b: assert property (p_sig_b) else $error("b bit force");
  property p_ebit;
    @(posedge pclk) disable iff (!presetn)
    ebit_tx |-> $past(crc_error) && $past(crc_on);
  endproperty
  a_ebit: assert property (p_ebit) else $error("bad e-bit");
  property p_reacq;
    @(posedge pclk) disable iff (!presetn)
    frame_reacquire |-> !$past(crc_mf_sync);
  endproperty
  a_reacq: assert property (p_reacq) else $error("reacquire with sync");
  c_recentre: cover property (@(posedge pclk) disable iff (!presetn) buffer_recentre);
  c_reacq: cover property (@(posedge pclk) disable iff (!presetn) frame_reacquire);
  c_deferred: cover property (@(posedge pclk) disable iff (!presetn) $rose(deferred_alarm));
  c_regen: cover property (@(posedge pclk) disable iff (!presetn) force_all_ones && !prompt_alarm);
  c_sig: cover property (@(posedge pclk) disable iff (!presetn) sig_override.sig_force != 4'h0);
endmodule // traffic_alarm_consequent_actions

// File: verif/far_end_model.sv
`timescale 1ns/1ns
module far_end_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ebit_tx,
  output logic crc_error,
  output logic ebit_rx,
  output logic backward_alarm_rx,
  output logic crc_mf_sync
);
  int ebits_seen;
  initial begin
    crc_error = 1'b0;
    ebit_rx = 1'b0;
    backward_alarm_rx = 1'b0;
    crc_mf_sync = 1'b1;
  end
  // ----------------------------------------------------------------
  // e-bits returned towards us, one per errored crc
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ebits_seen <= 0;
    end else if (ebit_tx === 1'b1) begin
      ebits_seen <= ebits_seen + 1;
    end
  end
  task automatic pulse_crc(input int n);
    repeat (n) begin
      @(posedge pclk);
      crc_error <= 1'b1;
      @(posedge pclk);
      crc_error <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic pulse_ebit(input int n);
    repeat (n) begin
      @(posedge pclk);
      ebit_rx <= 1'b1;
      @(posedge pclk);
      ebit_rx <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic set_bwd(input logic v);
    @(posedge pclk);
    backward_alarm_rx <= v;
  endtask
  task automatic set_sync(input logic v);
    @(posedge pclk);
    crc_mf_sync <= v;
  endtask
endmodule // far_end_model

// File: verif/traffic_alarm_consequent_actions_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module traffic_alarm_consequent_actions_test
  import traffic_alarm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_traffic_fail, high_error, all_ones_detected, auto_uplink_power_control;
  logic [15:0] user_err_est, demod_ebno, distant_ebno;
  logic buffer_slip, backward_alarm_rx, crc_error, ebit_rx, crc_mf_sync, irq;
  logic buffer_recentre, prompt_alarm, deferred_alarm, force_all_ones, backward_alarm_tx;
  logic insert_backward_alarm, ebit_tx, frame_reacquire;
  sig_ovr_t sig_override;
  int fail_count, check_count, reacq_n, centre_n;
  traffic_alarm_consequent_actions #(.CRC_SYNC_CYCLES(20), .HOUR_CYCLES(10))
    traffic_alarm_consequent_actions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_traffic_fail, .high_error, .all_ones_detected,
    .user_err_est, .demod_ebno, .distant_ebno, .auto_uplink_power_control, .buffer_slip,
    .backward_alarm_rx, .crc_error, .ebit_rx, .crc_mf_sync, .buffer_recentre, .prompt_alarm,
    .deferred_alarm, .force_all_ones, .backward_alarm_tx, .insert_backward_alarm,
    .sig_override, .ebit_tx, .frame_reacquire, .irq);
  far_end_model far_end_model_i (.pclk, .presetn, .ebit_tx, .crc_error, .ebit_rx,
    .backward_alarm_rx, .crc_mf_sync);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (frame_reacquire === 1'b1) reacq_n++;
    if (buffer_recentre === 1'b1) centre_n++;
  end
  // ----------------------------------------------------------------
  // bus helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc(ADDR_CTRL, 32'h00000007);
    rdc(ADDR_BER_THR, 32'h0000FFFF);
    rdc(ADDR_SLIP_THR, 32'h000003C0);
    apb(1'b0, 12'h028, 32'h0);
    `CHK(err, 1'b1)
  endtask
  task automatic t_ber;
    high_error <= 1'b1;
    tick(3);
    `CHK({prompt_alarm, force_all_ones, backward_alarm_tx}, 3'b111)
    rdc(ADDR_STATUS, 32'h0000000D);
    wr(ADDR_STATUS, 32'h0);
    rdc(ADDR_STATUS, 32'h0000000D);
    wr(ADDR_CTRL, 32'h00000005);
    tick(3);
    `CHK({prompt_alarm, force_all_ones, backward_alarm_tx}, 3'b100)
    high_error <= 1'b0;
    tick(3);
    `CHK(prompt_alarm, 1'b0)
  endtask
  task automatic t_ais;
    logic [15:0] c [3] = '{16'h0007, 16'h0003, 16'h0107};
    logic [2:0] x [3] = '{3'b111, 3'b000, 3'b010};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, {16'h0, c[i]});
      all_ones_detected <= 1'b1;
      tick(3);
      `CHK({prompt_alarm, force_all_ones, backward_alarm_tx}, x[i])
      all_ones_detected <= 1'b0;
      tick(3);
      `CHK({prompt_alarm, force_all_ones, backward_alarm_tx}, 3'b000)
    end
  endtask
  task automatic t_back;
    logic [4:0] x [4] = '{5'b10000, 5'b01111, 5'b00100, 5'b01100};
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, 32'h00000607 | (m << 3));
      far_end_model_i.set_bwd(1'b1);
      tick(3);
      `CHK({insert_backward_alarm, sig_override.sig_force}, x[m])
      `CHK(sig_override.sig_value, 4'hF)
      far_end_model_i.set_bwd(1'b0);
      tick(3);
      `CHK({insert_backward_alarm, sig_override.sig_force}, 5'h00)
    end
  endtask
  task automatic t_crc;
    wr(ADDR_CTRL, 32'h00001947);
    far_end_model_i.pulse_crc(2);
    tick(4);
    rdc(ADDR_CRC_CNT, 32'h0);
    `CHK(far_end_model_i.ebits_seen, 0)
    wr(ADDR_CTRL, 32'h00001967);
    far_end_model_i.pulse_crc(3);
    tick(4);
    rdc(ADDR_CRC_CNT, 32'h00000003);
    `CHK(far_end_model_i.ebits_seen, 3)
    far_end_model_i.pulse_ebit(2);
    tick(4);
    rdc(ADDR_EBIT_CNT, 32'h00000002);
    wr(ADDR_CTRL, 32'h00001167);
    far_end_model_i.pulse_crc(1);
    tick(4);
    rdc(ADDR_CRC_CNT, 32'h00000003);
    `CHK(far_end_model_i.ebits_seen, 4)
  endtask
  task automatic t_reacq;
    int r0;
    wr(ADDR_CTRL, 32'h000019E7);
    far_end_model_i.set_sync(1'b0);
    r0 = reacq_n;
    tick(40);
    `CHK(reacq_n != r0, 1'b1)
    far_end_model_i.set_sync(1'b1);
    tick(3);
    r0 = reacq_n;
    tick(45);
    `CHK(reacq_n - r0, 0)
  endtask
  task automatic t_def;
    wr(ADDR_CTRL, 32'h00000007);
    wr(ADDR_BER_THR, 32'h00000100);
    user_err_est <= 16'h0101;
    tick(3);
    `CHK(deferred_alarm, 1'b1)
    user_err_est <= 16'h0100;
    tick(3);
    `CHK(deferred_alarm, 1'b0)
    wr(ADDR_EBNO_THR, 32'h00000200);
    demod_ebno <= 16'h01FF;
    tick(3);
    `CHK(deferred_alarm, 1'b1)
    demod_ebno <= 16'h0200;
    tick(3);
    `CHK(deferred_alarm, 1'b0)
    wr(ADDR_DIST_THR, 32'h00000300);
    distant_ebno <= 16'h02FF;
    tick(3);
    `CHK(deferred_alarm, 1'b0)
    auto_uplink_power_control <= 1'b1;
    tick(3);
    `CHK(deferred_alarm, 1'b1)
    auto_uplink_power_control <= 1'b0;
    tick(3);
  endtask
  task automatic slip;
    buffer_slip <= 1'b1;
    @(posedge pclk);
    buffer_slip <= 1'b0;
  endtask
  task automatic t_slip;
    wr(ADDR_SLIP_THR, 32'h00000003);
    slip();
    tick(10);
    slip();
    tick(3);
    `CHK(deferred_alarm, 1'b1)
    tick(50);
    slip();
    tick(3);
    `CHK(deferred_alarm, 1'b0)
  endtask
  task automatic t_centre;
    int c0;
    for (int e = 1; e >= 0; e--) begin
      wr(ADDR_CTRL, 32'h00000006 | e);
      rx_traffic_fail <= 1'b1;
      tick(5);
      c0 = centre_n;
      rx_traffic_fail <= 1'b0;
      tick(6);
      `CHK(centre_n - c0, e)
    end
  endtask
  task automatic t_irq;
    logic ia;
    wr(ADDR_CTRL, 32'h00000007);
    wr(ADDR_IRQ_STAT, 32'h0000001F);
    wr(ADDR_IRQ_MASK, 32'h0);
    high_error <= 1'b1;
    tick(3);
    high_error <= 1'b0;
    tick(3);
    rdc(ADDR_IRQ_STAT, 32'h00000001);
    tick(2);
    ia = irq;
    wr(ADDR_IRQ_MASK, 32'h0000001F);
    tick(3);
    `CHK(ia, 1'b0)
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_STAT, 32'h0000001F);
    tick(3);
    `CHK(irq, 1'b0)
    rdc(ADDR_IRQ_STAT, 32'h0);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {rx_traffic_fail, high_error, all_ones_detected, auto_uplink_power_control} = 4'h0;
    buffer_slip = 1'b0;
    user_err_est = 16'h0000;
    demod_ebno = 16'hFFFF;
    distant_ebno = 16'hFFFF;
    tick(12);
    presetn <= 1'b1;
    tick(2);
    t_regs();
    t_ber();
    t_ais();
    t_back();
    t_crc();
    t_reacq();
    t_def();
    t_slip();
    t_centre();
    t_irq();
    stop_test();
  end
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule // traffic_alarm_consequent_actions_test
